// ==== design/wip_map.svh ====
`ifndef WIP_MAP_SVH
`define WIP_MAP_SVH

// register byte offsets
`define WIP_OFF_CTRL       8'h00
`define WIP_OFF_OTP        8'h04
`define WIP_OFF_MAIN_MASK  8'h08
`define WIP_OFF_FS_MASK    8'h0C
`define WIP_OFF_MAIN_FLAG  8'h10
`define WIP_OFF_FS_FLAG    8'h14
`define WIP_OFF_STATUS     8'h18

// control fields
`define WIP_CTRL_STANDBY   0
`define WIP_CTRL_POWER_UP  1

// fuse shadow fields
`define WIP_OTP_PARTNER    0
`define WIP_OTP_ENABLE     1
`define WIP_OTP_DLY_EXT    2

// main flag layout
`define WIP_MAIN_WAKE_A    14
`define WIP_MAIN_WAKE_B    15
`define WIP_MAIN_COM       16

// status fields
`define WIP_ST_WAKE_LSB    0
`define WIP_ST_BIAS        2
`define WIP_ST_PREREG      3
`define WIP_ST_IRQ_BUSY    4
`define WIP_ST_SYNC_LINE   5
`define WIP_ST_IRQ_LINE    6
`define WIP_ST_SEQ_LSB     8

// reset values
`define WIP_RST_CTRL       2'h0
`define WIP_RST_OTP        3'h0
`define WIP_RST_MAIN_MASK  17'h00000
`define WIP_RST_FS_MASK    6'h00

// timing
`define WIP_CLK_MHZ        250
`define WIP_IRQ_PULSE_US   100
`define WIP_PDN_DLY_US     250
`define WIP_PDN_EXT_US     32000
`define WIP_PDN_SHORT_CYC  1

`endif

// ==== design/wip_pkg.sv ====
package wip_pkg;

    typedef struct packed {
        logic a_dig;
        logic b_dig;
        logic a_alow;
        logic b_alow;
    } wip_wake_t;

    typedef struct packed {
        logic        com_err;
        logic [13:0] main;
        logic [5:0]  fs;
    } wip_src_t;

    typedef enum logic [5:0] {
        SQ_OFF  = 6'h01,
        SQ_SYNC = 6'h02,
        SQ_PRE  = 6'h04,
        SQ_PGW  = 6'h08,
        SQ_ON   = 6'h10,
        SQ_PDN  = 6'h20
    } wip_seq_t;

endpackage : wip_pkg

// ==== design/wip_sync.sv ====
module wip_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // wip_sync

// ==== design/wip_timer.sv ====
module wip_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        load,
    input  wire logic [22:0] len,
    // state
    output logic             busy,
    output logic             done
);
    logic [22:0] cnt_r;

    // a load while running is ignored so a pulse is never cut short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 23'h000000;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy && load) begin
                cnt_r <= len - 23'h000001;
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_r == 23'h000000) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 23'h000001;
                end
            end
        end
    end
endmodule // wip_timer

// ==== design/wip_pins.sv ====
// Function
// - wake input above high threshold reads one and starts biasing
// - both wakes below analog low stop biasing, only in standby
// - open-drain interrupt pin pulses low on an interrupt event; events during a running pulse start no new one
// - interrupt pulse lasts nominally 100 us
// - per-source inhibit bit blocks that source's pulse
// - main sources: supply, bias, pre-regulator, bucks, linear, wakes, bus error
// - fail-safe sources: six over/undervoltage monitor events
// - fuse bit picks partner: 0 twin device, 1 external PMIC
// - sync only acts when its fuse enable is set
// - twin mode: pause before pre-regulator start until partner ready
// - PMIC mode: pause after pre-regulator start until power good released
// - PMIC mode turn-off delay 250 us, or 32 ms when extended
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`include "wip_map.svh"

module wip_pins #(
    parameter logic [22:0] IRQ_PULSE_CYC = 23'(`WIP_IRQ_PULSE_US * `WIP_CLK_MHZ),
    parameter logic [22:0] PDN_DLY_CYC   = 23'(`WIP_PDN_DLY_US * `WIP_CLK_MHZ),
    parameter logic [22:0] PDN_EXT_CYC   = 23'(`WIP_PDN_EXT_US * `WIP_CLK_MHZ)
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [31:0]       hrdata,
    // wake comparators
    input  wire wip_pkg::wip_wake_t wake,
    // interrupt sources
    input  wire wip_pkg::wip_src_t src,
    // interrupt pin
    input  wire logic              irq_out_n_i,
    output logic                   irq_out_n_o,
    output logic                   irq_out_n_oe_n,
    // power sequence sync pin
    input  wire logic              power_sequence_sync_pin_i,
    output logic                   power_sequence_sync_pin_o,
    output logic                   power_sequence_sync_pin_oe_n,
    // supply enables
    output logic                   bias_supply_en,
    output logic                   pre_regulator_en
);
    import wip_pkg::*;

    localparam int AW = $bits(wip_wake_t) + $bits(wip_src_t) + 2;
    localparam logic [2:0] I_CTRL   = 3'(`WIP_OFF_CTRL >> 2);
    localparam logic [2:0] I_OTP    = 3'(`WIP_OFF_OTP >> 2);
    localparam logic [2:0] I_MMASK  = 3'(`WIP_OFF_MAIN_MASK >> 2);
    localparam logic [2:0] I_FMASK  = 3'(`WIP_OFF_FS_MASK >> 2);
    localparam logic [2:0] I_MFLAG  = 3'(`WIP_OFF_MAIN_FLAG >> 2);
    localparam logic [2:0] I_FFLAG  = 3'(`WIP_OFF_FS_FLAG >> 2);
    localparam logic [2:0] I_STATUS = 3'(`WIP_OFF_STATUS >> 2);

    // set beats clear so an event in the clearing cycle survives
    function automatic logic [16:0] w1c(input logic [16:0] f,
                                        input logic [16:0] e,
                                        input logic [16:0] c);
        return (f & ~c) | e;
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        return (a[31:5] == 27'h0000000) && (a[4:2] != 3'h7) && (a[1:0] == 2'h0);
    endfunction

    // pin inputs
    logic [AW-1:0] async_in;
    logic [AW-1:0] async_q;
    wip_wake_t     wake_s;
    wip_src_t      src_s;
    logic          irq_line_s;
    logic          sync_line_s;

    // registers
    logic [1:0]    ctrl_r;
    logic [2:0]    otp_r;
    logic [16:0]   mmask_r;
    logic [5:0]    fmask_r;
    logic [16:0]   mflag_r;
    logic [5:0]    fflag_r;

    // bus
    logic          ph_r;
    logic          ph_wr_r;
    logic          ph_map_r;
    logic [2:0]    ph_idx_r;
    logic          take;
    logic          wr_en;
    logic [31:0]   rd_nxt;

    // events
    logic [1:0]    wake_dig;
    logic [1:0]    wake_prev_r;
    logic [1:0]    wake_edge;
    logic [14:0]   main_lvl;
    logic [14:0]   main_prev_r;
    logic [5:0]    fs_prev_r;
    logic [16:0]   mevt;
    logic [5:0]    fevt;
    logic          irq_fire;
    logic          irq_busy;

    // sequencer
    wip_seq_t      seq_r;
    wip_seq_t      seq_nxt;
    logic          sync_en;
    logic          pmic_mode;
    logic          up_req;
    logic          pdn_load;
    logic [22:0]   pdn_len;
    logic          pdn_done;

    assign async_in = {wake, src, irq_out_n_i, power_sequence_sync_pin_i};

    wip_sync #(
        .W     (AW)
    ) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     (async_in),
        .q     (async_q)
    );

    assign {wake_s, src_s, irq_line_s, sync_line_s} = async_q;

    // bus front end: one wait state on every transfer
    assign take  = hsel && htrans[1] && hready;
    assign wr_en = ph_r && ph_wr_r && ph_map_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_r      <= 1'b0;
            ph_wr_r   <= 1'b0;
            ph_map_r  <= 1'b0;
            ph_idx_r  <= 3'h0;
            hreadyout <= 1'b1;
        end else if (take) begin
            ph_r      <= 1'b1;
            ph_wr_r   <= hwrite;
            ph_map_r  <= is_mapped(haddr);
            ph_idx_r  <= haddr[4:2];
            hreadyout <= 1'b0;
        end else if (ph_r) begin
            ph_r      <= 1'b0;
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_comb begin
        rd_nxt = 32'h00000000;
        if (ph_map_r) begin
            case (ph_idx_r)
                I_CTRL:   rd_nxt = {30'h00000000, ctrl_r};
                I_OTP:    rd_nxt = {29'h00000000, otp_r};
                I_MMASK:  rd_nxt = {15'h0000, mmask_r};
                I_FMASK:  rd_nxt = {26'h0000000, fmask_r};
                I_MFLAG:  rd_nxt = {15'h0000, mflag_r};
                I_FFLAG:  rd_nxt = {26'h0000000, fflag_r};
                I_STATUS: begin
                    rd_nxt[`WIP_ST_WAKE_LSB +: 2] = wake_prev_r;
                    rd_nxt[`WIP_ST_BIAS]          = bias_supply_en;
                    rd_nxt[`WIP_ST_PREREG]        = pre_regulator_en;
                    rd_nxt[`WIP_ST_IRQ_BUSY]      = irq_busy;
                    rd_nxt[`WIP_ST_SYNC_LINE]     = sync_line_s;
                    rd_nxt[`WIP_ST_IRQ_LINE]      = irq_line_s;
                    rd_nxt[`WIP_ST_SEQ_LSB +: 6]  = seq_r;
                end
                default:  rd_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ph_r && !ph_wr_r) begin
            hrdata <= rd_nxt;
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r  <= `WIP_RST_CTRL;
            otp_r   <= `WIP_RST_OTP;
            mmask_r <= `WIP_RST_MAIN_MASK;
            fmask_r <= `WIP_RST_FS_MASK;
        end else if (wr_en) begin
            if (ph_idx_r == I_CTRL) begin
                ctrl_r <= hwdata[1:0];
            end
            if (ph_idx_r == I_OTP) begin
                otp_r <= hwdata[2:0];
            end
            if (ph_idx_r == I_MMASK) begin
                mmask_r <= hwdata[16:0];
            end
            if (ph_idx_r == I_FMASK) begin
                fmask_r <= hwdata[5:0];
            end
        end
    end

    assign wake_dig  = {wake_s.b_dig, wake_s.a_dig};
    assign wake_edge = wake_dig ^ wake_prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_prev_r <= 2'h0;
        end else begin
            wake_prev_r <= wake_dig;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bias_supply_en <= 1'b0;
        end else if (|wake_dig) begin
            bias_supply_en <= 1'b1;
        end else if (wake_s.a_alow && wake_s.b_alow && ctrl_r[`WIP_CTRL_STANDBY]) begin
            bias_supply_en <= 1'b0;
        end
    end

    // sources are levels; a rising edge counts as a new event, but a wake counts on either edge
    assign main_lvl = {src_s.com_err, src_s.main};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_prev_r <= 15'h0000;
            fs_prev_r   <= 6'h00;
        end else begin
            main_prev_r <= main_lvl;
            fs_prev_r   <= src_s.fs;
        end
    end

    assign mevt = {main_lvl[14], wake_edge, main_lvl[13:0] & ~main_prev_r[13:0]}
                & {~main_prev_r[14], 16'hFFFF};
    assign fevt = src_s.fs & ~fs_prev_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mflag_r <= 17'h00000;
            fflag_r <= 6'h00;
        end else begin
            mflag_r <= w1c(mflag_r, mevt,
                           (wr_en && ph_idx_r == I_MFLAG) ? hwdata[16:0] : 17'h00000);
            fflag_r <= 6'(w1c(17'(fflag_r), 17'(fevt),
                              (wr_en && ph_idx_r == I_FFLAG) ? 17'(hwdata[5:0])
                                                              : 17'h00000));
        end
    end

    assign irq_fire = (|(mevt & ~mmask_r)) || (|(fevt & ~fmask_r));

    wip_timer u_irq_timer (
        .clk   (hclk),
        .rst_n (hresetn),
        .load  (irq_fire),
        .len   (IRQ_PULSE_CYC),
        .busy  (irq_busy),
        .done  ()
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out_n_o    <= 1'b0;
            irq_out_n_oe_n <= 1'b1;
        end else begin
            irq_out_n_o    <= 1'b0;
            irq_out_n_oe_n <= !irq_busy;
        end
    end

    assign pmic_mode = otp_r[`WIP_OTP_PARTNER];
    assign sync_en   = otp_r[`WIP_OTP_ENABLE];
    assign up_req    = ctrl_r[`WIP_CTRL_POWER_UP] && bias_supply_en;

    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SQ_OFF: begin
                if (up_req) begin
                    seq_nxt = SQ_SYNC;
                end
            end
            SQ_SYNC: begin
                if (!up_req) begin
                    seq_nxt = SQ_OFF;
                end else if (!sync_en || pmic_mode || sync_line_s) begin
                    seq_nxt = SQ_PRE;
                end
            end
            SQ_PRE: begin
                if (sync_en && pmic_mode) begin
                    seq_nxt = SQ_PGW;
                end else begin
                    seq_nxt = SQ_ON;
                end
            end
            SQ_PGW: begin
                if (!up_req) begin
                    seq_nxt = SQ_PDN;
                end else if (sync_line_s) begin
                    seq_nxt = SQ_ON;
                end
            end
            SQ_ON: begin
                if (!up_req) begin
                    seq_nxt = SQ_PDN;
                end
            end
            SQ_PDN: begin
                if (pdn_done) begin
                    seq_nxt = SQ_OFF;
                end
            end
            default: seq_nxt = SQ_OFF;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_r <= SQ_OFF;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    assign pdn_load = (seq_r != SQ_PDN) && (seq_nxt == SQ_PDN);
    assign pdn_len  = !(sync_en && pmic_mode) ? 23'(`WIP_PDN_SHORT_CYC)
                    : otp_r[`WIP_OTP_DLY_EXT] ? PDN_EXT_CYC : PDN_DLY_CYC;

    wip_timer u_pdn_timer (
        .clk   (hclk),
        .rst_n (hresetn),
        .load  (pdn_load),
        .len   (pdn_len),
        .busy  (),
        .done  (pdn_done)
    );

    // pre-regulator stays on until the turn-off delay ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_regulator_en <= 1'b0;
        end else begin
            pre_regulator_en <= (seq_nxt != SQ_OFF) && (seq_nxt != SQ_SYNC);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_sequence_sync_pin_o    <= 1'b0;
            power_sequence_sync_pin_oe_n <= 1'b1;
        end else begin
            power_sequence_sync_pin_o    <= 1'b0;
            power_sequence_sync_pin_oe_n <= !(sync_en && !pmic_mode && seq_nxt == SQ_OFF);
        end
    end

endmodule // wip_pins

// ==== testbench/wip_pins_assertions.sv ====
module wip_pins_chk #(
    parameter logic [22:0] IRQ_PULSE_CYC = 23'h0061A8
) (
    // clock and reset
    input wire logic               hclk,
    input wire logic               hresetn,
    // bus
    input wire logic               hsel,
    input wire logic [1:0]         htrans,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    // pins
    input wire wip_pkg::wip_wake_t wake,
    input wire logic               irq_out_n_o,
    input wire logic               irq_out_n_oe_n,
    input wire logic               power_sequence_sync_pin_o,
    input wire logic               power_sequence_sync_pin_oe_n,
    input wire logic               bias_supply_en,
    input wire logic               pre_regulator_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import wip_pkg::*;

    // counts low cycles of the interrupt pin, so pulse length is checked exactly
    logic [22:0] low_cnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt_r <= 23'h0;
        end else begin
            low_cnt_r <= irq_out_n_oe_n ? 23'h0 : low_cnt_r + 23'h1;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_take; hsel && htrans[1] && hready |=> !hreadyout; endproperty
    a_take: assert property (p_take) else $error("taken request did not stall");
    property p_ready; !hreadyout |=> hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state longer than one cycle");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_irq_od; irq_out_n_o == 1'b0; endproperty
    a_irq_od: assert property (p_irq_od) else $error("interrupt pin drives high");
    property p_pulse_len; $rose(irq_out_n_oe_n) |-> low_cnt_r == IRQ_PULSE_CYC; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
    property p_pulse_max; !irq_out_n_oe_n |-> low_cnt_r < IRQ_PULSE_CYC; endproperty
    a_pulse_max: assert property (p_pulse_max) else $error("pulse extended");
    property p_bias_on; (wake.a_dig || wake.b_dig) [*4] |=> bias_supply_en; endproperty
    a_bias_on: assert property (p_bias_on) else $error("bias not started");
    property p_bias_keep;
        (!(wake.a_alow && wake.b_alow)) [*5] |=> !$fell(bias_supply_en);
    endproperty
    a_bias_keep: assert property (p_bias_keep) else $error("bias stopped early");
    property p_sync_od; power_sequence_sync_pin_o == 1'b0; endproperty
    a_sync_od: assert property (p_sync_od) else $error("sync pin drives high");
    property p_pre_free;
        $rose(pre_regulator_en) |-> power_sequence_sync_pin_oe_n
            && $past(power_sequence_sync_pin_oe_n);
    endproperty
    a_pre_free: assert property (p_pre_free) else $error("start while line held");

    c_pulse: cover property ($rose(irq_out_n_oe_n));
    c_pre: cover property ($rose(pre_regulator_en));
    c_hold: cover property ($fell(power_sequence_sync_pin_oe_n));
    c_stop: cover property ($fell(bias_supply_en));
endmodule // wip_pins_chk

bind wip_pins wip_pins_chk #(.IRQ_PULSE_CYC(IRQ_PULSE_CYC)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .wake(wake), .irq_out_n_o(irq_out_n_o),
    .irq_out_n_oe_n(irq_out_n_oe_n), .power_sequence_sync_pin_o(power_sequence_sync_pin_o),
    .power_sequence_sync_pin_oe_n(power_sequence_sync_pin_oe_n),
    .bias_supply_en(bias_supply_en), .pre_regulator_en(pre_regulator_en)
);

// ==== testbench/wip_far_model.sv ====
module wip_far_model (
    // clock
    input  wire logic        hclk,
    // device pin enables
    input  wire logic        irq_oe_n,
    input  wire logic        sync_oe_n,
    // partner holds sync line low (twin not ready, or power good not released)
    input  wire logic        hold_low,
    // resolved lines
    output logic             irq_line,
    output logic             sync_line,
    // host pulse monitor
    output logic [7:0]       pulses,
    output logic [22:0]      last_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] run;

    assign irq_line = irq_oe_n;
    // shared pulled-up line, either party pulls low
    assign sync_line = sync_oe_n & ~hold_low;

    initial begin
        pulses = 8'h0;
        last_len = 23'h0;
        run = 23'h0;
    end

    // host times every low pulse it sees
    always @(posedge hclk) begin
        if (!irq_line) begin
            run <= run + 23'h1;
        end else if (run != 23'h0) begin
            pulses <= pulses + 8'h1;
            last_len <= run;
            run <= 23'h0;
        end
    end
endmodule // wip_far_model

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wip_pkg::*;
    // short counts keep the run brief
    localparam logic [22:0] PULSE = 23'h14;
    localparam logic [22:0] PDN = 23'h1E;
    localparam logic [22:0] PDN_EXT = 23'h3C;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hold;
    logic        irq_oe_n, irq_o, sync_oe_n, sync_o, bias, pre, irq_line, sync_line;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [7:0]  pulses, p0;
    logic [22:0] last_len;
    wip_wake_t   wk;
    wip_src_t    src_s;
    int          failures, cmp_count, n, lim, i, j, k;

    wip_pins #(.IRQ_PULSE_CYC(PULSE), .PDN_DLY_CYC(PDN), .PDN_EXT_CYC(PDN_EXT)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake(wk), .src(src_s),
        .irq_out_n_i(irq_line), .irq_out_n_o(irq_o), .irq_out_n_oe_n(irq_oe_n),
        .power_sequence_sync_pin_i(sync_line), .power_sequence_sync_pin_o(sync_o),
        .power_sequence_sync_pin_oe_n(sync_oe_n), .bias_supply_en(bias),
        .pre_regulator_en(pre));
    wip_far_model u_far (.hclk(hclk), .irq_oe_n(irq_oe_n), .sync_oe_n(sync_oe_n),
        .hold_low(hold), .irq_line(irq_line), .sync_line(sync_line), .pulses(pulses),
        .last_len(last_len));

    always #2 hclk = ~hclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // flag bit of source k: 0..5 fail-safe, 6..19 main, 20 bus error
    function automatic logic [31:0] flag_exp(input int k);
        if (k < 6) return 32'h1 << k;
        if (k == 20) return 32'h10000;
        return 32'h1 << (k - 6);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic fire(input int k);
        src_s <= wip_src_t'(21'h1 << k);
        repeat (4) @(posedge hclk);
        src_s <= wip_src_t'(21'h0);
    endtask

    task automatic wait_pre(input logic v);
        n = 0;
        while (pre !== v && n < 200) begin
            @(posedge hclk);
            n++;
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        final_report;
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wk = wip_wake_t'(4'h0);
        src_s = wip_src_t'(21'h0);
        hold = 1'b0;
        seed = 32'h0121EC16;
        failures = 0;
        cmp_count = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, status shows idle lines high and sequencer off
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            check(rd, a == 24 ? 32'h160 : 32'h0);
        end
        for (int r = 0; r < 4; r++) begin
            seed = xs(seed);
            bus(1'b1, r[0] ? 8'h0C : 8'h08, seed);
            bus(1'b0, r[0] ? 8'h0C : 8'h08, 32'h0);
            check(rd, seed & (r[0] ? 32'h3F : 32'h1FFFF));
        end
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h0C, 32'h0);
        $display("test registers done");
        wk <= wip_wake_t'(4'h8);
        repeat (8) @(posedge hclk);
        check(bias, 1'b1);
        bus(1'b0, 8'h18, 32'h0);
        check(rd[1:0], 2'h1);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h4000);
        wk <= wip_wake_t'(4'h3);
        repeat (8) @(posedge hclk);
        check(bias, 1'b1);
        bus(1'b1, 8'h00, 32'h1);
        repeat (8) @(posedge hclk);
        check(bias, 1'b0);
        bus(1'b1, 8'h00, 32'h0);
        wk <= wip_wake_t'(4'h8);
        repeat (40) @(posedge hclk);
        bus(1'b1, 8'h10, 32'h1FFFF);
        $display("test wake done");
        for (k = 0; k < 21; k++) begin
            p0 = pulses;
            fire(k);
            repeat (40) @(posedge hclk);
            check(pulses - p0, 8'h1);
            check(last_len, PULSE);
            bus(1'b0, k < 6 ? 8'h14 : 8'h10, 32'h0);
            check(rd, flag_exp(k));
            bus(1'b1, k < 6 ? 8'h14 : 8'h10, 32'hFFFFFFFF);
        end
        $display("test sources done");
        seed = xs(seed);
        i = int'(seed % 14) + 6;
        j = int'(seed[15:8] % 6);
        p0 = pulses;
        fire(i);
        repeat (6) @(posedge hclk);
        fire(j);
        repeat (50) @(posedge hclk);
        check(pulses - p0, 8'h1);
        check(last_len, PULSE);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, flag_exp(i));
        bus(1'b0, 8'h14, 32'h0);
        check(rd, flag_exp(j));
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        bus(1'b1, 8'h14, 32'hFFFFFFFF);
        for (int m = 0; m < 2; m++) begin
            k = m ? j : i;
            bus(1'b1, m ? 8'h0C : 8'h08, flag_exp(k));
            p0 = pulses;
            fire(k);
            repeat (40) @(posedge hclk);
            check(pulses - p0, 8'h0);
            bus(1'b0, m ? 8'h14 : 8'h10, 32'h0);
            check(rd, flag_exp(k));
            bus(1'b1, m ? 8'h14 : 8'h10, 32'hFFFFFFFF);
            bus(1'b1, m ? 8'h0C : 8'h08, 32'h0);
        end
        $display("test overlap and mask done");
        hold <= 1'b1;
        bus(1'b1, 8'h04, 32'h2);
        repeat (4) @(posedge hclk);
        check(sync_oe_n, 1'b0);
        bus(1'b1, 8'h00, 32'h2);
        repeat (30) @(posedge hclk);
        check(pre, 1'b0);
        bus(1'b0, 8'h18, 32'h0);
        check(rd[13:8], SQ_SYNC);
        hold <= 1'b0;
        wait_pre(1'b1);
        check(pre, 1'b1);
        bus(1'b1, 8'h00, 32'h0);
        wait_pre(1'b0);
        $display("test twin done");
        for (int e = 0; e < 2; e++) begin
            hold <= 1'b1;
            bus(1'b1, 8'h04, e ? 32'h7 : 32'h3);
            bus(1'b1, 8'h00, 32'h2);
            wait_pre(1'b1);
            repeat (30) @(posedge hclk);
            check(pre, 1'b1);
            bus(1'b0, 8'h18, 32'h0);
            check(rd[13:8], SQ_PGW);
            hold <= 1'b0;
            repeat (10) @(posedge hclk);
            bus(1'b0, 8'h18, 32'h0);
            check(rd[13:8], SQ_ON);
            lim = e ? int'(PDN_EXT) : int'(PDN);
            bus(1'b1, 8'h00, 32'h0);
            wait_pre(1'b0);
            check(n >= lim - 2 && n <= lim + 6, 1'b1);
        end
        $display("test external done");
        hold <= 1'b1;
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h2);
        repeat (20) @(posedge hclk);
        bus(1'b0, 8'h18, 32'h0);
        check(rd[13:8], SQ_ON);
        check(sync_oe_n, 1'b1);
        $display("test disabled done");
        final_report;
    end
endmodule // testbench
